// ==== src/servo_ff_pkg.sv ====
// Constants, register map and types for the feedforward and P/PI switching block.
// Functional notes
// - Feedforward is the position command derivative times gain percent, added to velocity.
// - Feedforward low-pass bandwidth 0 to 2500 Hz, default 200; zero bypasses it.
// - The filter acts only while feedforward gain is nonzero.
// - Switching mode 0 disables automatic P-only switching; 4 is reserved.
// - Mode 1: P-only while torque command exceeds threshold in percent.
// - Mode 2: P-only while velocity command exceeds threshold in rpm.
// - Mode 3: P-only while position error exceeds threshold in pulses.
// - Threshold range 0 to 3000, default 100, unit follows mode.
// - Without a switching condition the velocity loop runs full PI.
// - In P-only operation the integral gain is treated as zero.
// - The force input makes P-only regardless of mode, threshold or state.
// - Feedforward gain and switching mode reset to zero.
package servo_ff_pkg;
	localparam logic [15:0] ADDR_SWITCH_MODE = 16'h2104;
	localparam logic [15:0] ADDR_SWITCH_THRESHOLD = 16'h2105;
	localparam logic [15:0] ADDR_FF_GAIN = 16'h2302;
	localparam logic [15:0] ADDR_FF_FILTER_BW = 16'h2303;
	localparam logic [15:0] ADDR_STATUS = 16'h2380;
	localparam logic [7:0] SWITCH_MODE_RESET = 8'h00;
	localparam logic [15:0] THRESHOLD_RESET = 16'h0064;
	localparam logic [7:0] FF_GAIN_RESET = 8'h00;
	localparam logic [15:0] FF_BW_RESET = 16'h00C8;
	localparam logic [7:0] FF_GAIN_MAX = 8'h64;
	localparam logic [15:0] FF_BW_MAX = 16'h09C4;
	localparam logic [15:0] THRESHOLD_MAX = 16'h0BB8;
	localparam logic [7:0] SWITCH_MODE_MAX = 8'h04;
	localparam logic [7:0] PERCENT_SCALE = 8'h64;
	localparam int BW_SHIFT = 16;
	localparam logic [31:0] ALPHA_PER_HZ = 32'h0000001A;
	localparam logic [15:0] ALPHA_MAX = 16'hFFFF;
	localparam logic [15:0] ROUND_HALF = 16'h8000;
	typedef enum logic [2:0] {
		MODE_OFF = 3'b000,
		MODE_TORQUE = 3'b001,
		MODE_VELOCITY = 3'b010,
		MODE_POS_ERROR = 3'b011,
		MODE_RESERVED = 3'b100
	} switch_mode_type;
endpackage

// ==== src/ff_lowpass.sv ====
// First-order recursive low-pass filter stepped once per control cycle.
module ff_lowpass
	import servo_ff_pkg::*;
#(
	parameter int WIDTH = 32
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic step,
	input wire logic bypass,
	input wire logic [15:0] alpha,
	input wire logic signed [WIDTH-1:0] sample,
	output logic signed [WIDTH-1:0] filtered
);
	logic signed [WIDTH+BW_SHIFT-1:0] state_q;
	logic signed [WIDTH+BW_SHIFT-1:0] state_d;
	logic signed [WIDTH+BW_SHIFT-1:0] target;
	logic signed [WIDTH+BW_SHIFT-1:0] rounded;
	logic signed [WIDTH+BW_SHIFT+17:0] delta_prod;
	logic signed [WIDTH+BW_SHIFT+17:0] step_full;
	// State keeps fraction bits so small steps do not stall the filter.
	assign target = (WIDTH+BW_SHIFT)'(sample) <<< BW_SHIFT;
	assign delta_prod = (WIDTH+BW_SHIFT+18)'(target - state_q) *
		$signed({1'b0, alpha});
	assign step_full = delta_prod >>> BW_SHIFT;
	// Output moves a fraction alpha of the way toward the input each cycle.
	assign state_d = bypass ? target :
		state_q + step_full[WIDTH+BW_SHIFT-1:0];
	assign rounded = state_q + (WIDTH+BW_SHIFT)'(ROUND_HALF);
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_q <= '0;
		end else if (step) begin
			state_q <= state_d;
		end
	end
	assign filtered = rounded[WIDTH+BW_SHIFT-1:BW_SHIFT];
endmodule

// ==== src/servo_ff_and_pi_switch.sv ====
// Position feedforward and P/PI velocity loop switching block.
module servo_ff_and_pi_switch
	import servo_ff_pkg::*;
#(
	parameter int CMD_WIDTH = 32,
	parameter int CYCLE_DIV = 1000
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic servo_on,
	input wire logic proportional_force_input,
	input wire logic signed [CMD_WIDTH-1:0] position_command,
	input wire logic signed [CMD_WIDTH-1:0] velocity_command_in,
	input wire logic signed [CMD_WIDTH-1:0] torque_percent,
	input wire logic signed [CMD_WIDTH-1:0] velocity_rpm,
	input wire logic signed [CMD_WIDTH-1:0] position_error,
	input wire logic [15:0] velocity_integral_gain_param,
	output logic signed [CMD_WIDTH-1:0] velocity_command_out,
	output logic [15:0] integral_gain_out,
	output logic p_only,
	output logic cycle_tick
);
	logic [7:0] mode_q;
	logic [15:0] threshold_q;
	logic [7:0] gain_q;
	logic [15:0] bw_q;
	logic [$clog2(CYCLE_DIV)-1:0] div_q;
	logic tick_q;
	logic signed [CMD_WIDTH-1:0] prev_pos_q;
	logic signed [CMD_WIDTH-1:0] vel_out_q;
	logic [15:0] integ_q;
	logic p_only_q;
	logic [15:0] rdata_q;
	logic signed [CMD_WIDTH-1:0] pos_delta;
	logic signed [CMD_WIDTH+8:0] scaled_full;
	logic signed [CMD_WIDTH-1:0] ff_raw;
	logic signed [CMD_WIDTH-1:0] ff_filt;
	logic signed [CMD_WIDTH-1:0] ff_term;
	logic signed [CMD_WIDTH-1:0] sel_quantity;
	logic [CMD_WIDTH-1:0] sel_abs;
	logic auto_cond;
	logic p_only_d;
	logic filter_bypass;
	logic [15:0] alpha;
	logic [31:0] alpha_full;
	logic wr_mode;
	logic wr_thr;
	logic wr_gain;
	logic wr_bw;
	logic hit_mode;
	logic hit_thr;
	logic hit_gain;
	logic hit_bw;
	logic hit_status;
	logic signed [CMD_WIDTH-1:0] thr_signed;
	logic [15:0] rdata_d;
	switch_mode_type mode_sel;

	assign hit_mode = reg_addr == ADDR_SWITCH_MODE;
	assign hit_thr = reg_addr == ADDR_SWITCH_THRESHOLD;
	assign hit_gain = reg_addr == ADDR_FF_GAIN;
	assign hit_bw = reg_addr == ADDR_FF_FILTER_BW;
	assign hit_status = reg_addr == ADDR_STATUS;

	assign wr_mode = reg_wr && hit_mode && !servo_on;
	assign wr_thr = reg_wr && hit_thr;
	assign wr_gain = reg_wr && hit_gain;
	assign wr_bw = reg_wr && hit_bw;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			mode_q <= SWITCH_MODE_RESET;
			threshold_q <= THRESHOLD_RESET;
			gain_q <= FF_GAIN_RESET;
			bw_q <= FF_BW_RESET;
		end else begin
			if (wr_mode && reg_wdata[7:0] <= SWITCH_MODE_MAX) begin
				mode_q <= reg_wdata[7:0];
			end
			if (wr_thr && reg_wdata <= THRESHOLD_MAX) begin
				threshold_q <= reg_wdata;
			end
			if (wr_gain && reg_wdata[7:0] <= FF_GAIN_MAX && reg_wdata[15:8] == 8'h00) begin
				gain_q <= reg_wdata[7:0];
			end
			if (wr_bw && reg_wdata <= FF_BW_MAX) begin
				bw_q <= reg_wdata;
			end
		end
	end

	assign rdata_d =
		hit_mode ? {8'h00, mode_q} :
		hit_thr ? threshold_q :
		hit_gain ? {8'h00, gain_q} :
		hit_bw ? bw_q :
		hit_status ? {15'h0000, p_only_q} : 16'h0000;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rdata_q <= 16'h0000;
		end else begin
			rdata_q <= reg_rd ? rdata_d : 16'h0000;
		end
	end
	assign reg_rdata = rdata_q;

	// Control cycle enable from the core clock divider.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			div_q <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= div_q == ($clog2(CYCLE_DIV))'(CYCLE_DIV - 1);
			div_q <= div_q == ($clog2(CYCLE_DIV))'(CYCLE_DIV - 1) ? '0 : div_q + 1'b1;
		end
	end
	assign cycle_tick = tick_q;

	assign pos_delta = position_command - prev_pos_q;
	assign scaled_full = (CMD_WIDTH+9)'(pos_delta) * $signed({1'b0, gain_q});
	assign ff_raw = CMD_WIDTH'(scaled_full / $signed({1'b0, PERCENT_SCALE}));
	assign filter_bypass = bw_q == 16'h0000 || gain_q == 8'h00;
	assign alpha_full = {16'h0000, bw_q} * ALPHA_PER_HZ;
	assign alpha = alpha_full[31:16] != 16'h0000 ? ALPHA_MAX : alpha_full[15:0];

	ff_lowpass #(
		.WIDTH(CMD_WIDTH)
	) u_lowpass (
		.core_clk(core_clk),
		.rst(rst),
		.step(tick_q),
		.bypass(filter_bypass),
		.alpha(alpha),
		.sample(ff_raw),
		.filtered(ff_filt)
	);
	assign ff_term = gain_q == 8'h00 ? '0 : ff_filt;

	assign mode_sel = switch_mode_type'(mode_q[2:0]);
	assign sel_quantity =
		mode_sel == MODE_TORQUE ? torque_percent :
		mode_sel == MODE_VELOCITY ? velocity_rpm :
		mode_sel == MODE_POS_ERROR ? position_error : '0;
	assign sel_abs = sel_quantity < 0 ? -sel_quantity : sel_quantity;
	assign auto_cond = (mode_sel == MODE_TORQUE || mode_sel == MODE_VELOCITY ||
		mode_sel == MODE_POS_ERROR) &&
		sel_abs > CMD_WIDTH'(threshold_q);
	assign p_only_d = proportional_force_input || auto_cond;
	assign thr_signed = $signed(CMD_WIDTH'(threshold_q));

	always_ff @(posedge core_clk) begin
		if (rst) begin
			prev_pos_q <= '0;
			vel_out_q <= '0;
			integ_q <= 16'h0000;
			p_only_q <= 1'b0;
		end else begin
			p_only_q <= p_only_d;
			integ_q <= p_only_d ? 16'h0000 : velocity_integral_gain_param;
			if (tick_q) begin
				prev_pos_q <= position_command;
			end
			vel_out_q <= velocity_command_in + ff_term;
		end
	end
	assign velocity_command_out = vel_out_q;
	assign integral_gain_out = integ_q;
	assign p_only = p_only_q;

	a_force_p_only: assert property (@(posedge core_clk) disable iff (rst)
		proportional_force_input |=> p_only && integral_gain_out == 16'h0000)
		else $error("force input did not give P-only operation");
	a_mode_off_pi: assert property (@(posedge core_clk) disable iff (rst)
		(mode_q == 8'h00 && !proportional_force_input) |=> !p_only)
		else $error("mode zero switched to P-only");
	a_pi_integral: assert property (@(posedge core_clk) disable iff (rst)
		!p_only_d |=> integral_gain_out == $past(velocity_integral_gain_param))
		else $error("PI operation lost integral gain");
	a_p_zero_integ: assert property (@(posedge core_clk) disable iff (rst)
		p_only |-> integral_gain_out == 16'h0000)
		else $error("integral gain not zero in P-only");
	a_mode_locked: assert property (@(posedge core_clk) disable iff (rst)
		servo_on |=> mode_q == $past(mode_q))
		else $error("switching mode changed while servo on");
	a_threshold_range: assert property (@(posedge core_clk) disable iff (rst)
		threshold_q <= THRESHOLD_MAX)
		else $error("threshold out of range");
	a_zero_gain_ff: assert property (@(posedge core_clk) disable iff (rst)
		gain_q == 8'h00 |=> velocity_command_out == $past(velocity_command_in))
		else $error("feedforward added with zero gain");
	a_torque_switch: assert property (@(posedge core_clk) disable iff (rst)
		(mode_q == 8'h01 && torque_percent > thr_signed) |=> p_only)
		else $error("torque mode did not switch");
	a_velocity_switch: assert property (@(posedge core_clk) disable iff (rst)
		(mode_q == 8'h02 && velocity_rpm > thr_signed) |=> p_only)
		else $error("velocity mode did not switch");
	a_poserr_switch: assert property (@(posedge core_clk) disable iff (rst)
		(mode_q == 8'h03 && position_error > thr_signed) |=> p_only)
		else $error("position error mode did not switch");
	a_gain_range: assert property (@(posedge core_clk) disable iff (rst)
		gain_q <= FF_GAIN_MAX && bw_q <= FF_BW_MAX)
		else $error("feedforward setting out of range");

	a_mode_reset: assert property (@(posedge core_clk) disable iff (rst)
		$fell(rst) |-> mode_q == SWITCH_MODE_RESET && gain_q == FF_GAIN_RESET)
		else $error("mode or gain not at reset value");
	a_thr_reset: assert property (@(posedge core_clk) disable iff (rst)
		$fell(rst) |-> threshold_q == THRESHOLD_RESET && bw_q == FF_BW_RESET)
		else $error("threshold or bandwidth not at reset value");
	a_mode_range: assert property (@(posedge core_clk) disable iff (rst)
		mode_q <= SWITCH_MODE_MAX)
		else $error("switching mode out of range");
	a_mode_write: assert property (@(posedge core_clk) disable iff (rst)
		(wr_mode && reg_wdata[7:0] <= SWITCH_MODE_MAX) |=>
		mode_q == $past(reg_wdata[7:0]))
		else $error("mode write while servo off lost");
	a_thr_write: assert property (@(posedge core_clk) disable iff (rst)
		(wr_thr && reg_wdata <= THRESHOLD_MAX) |=>
		threshold_q == $past(reg_wdata))
		else $error("threshold write lost");
	a_gain_write: assert property (@(posedge core_clk) disable iff (rst)
		(wr_gain && reg_wdata <= {8'h00, FF_GAIN_MAX}) |=>
		gain_q == $past(reg_wdata[7:0]))
		else $error("gain write lost");
	a_bw_write: assert property (@(posedge core_clk) disable iff (rst)
		(wr_bw && reg_wdata <= FF_BW_MAX) |=> bw_q == $past(reg_wdata))
		else $error("bandwidth write lost");
	a_bad_thr_kept: assert property (@(posedge core_clk) disable iff (rst)
		(wr_thr && reg_wdata > THRESHOLD_MAX) |=> $stable(threshold_q))
		else $error("out of range threshold accepted");
	a_bad_gain_kept: assert property (@(posedge core_clk) disable iff (rst)
		(wr_gain && reg_wdata[7:0] > FF_GAIN_MAX) |=> $stable(gain_q))
		else $error("out of range gain accepted");
	a_bad_bw_kept: assert property (@(posedge core_clk) disable iff (rst)
		(wr_bw && reg_wdata > FF_BW_MAX) |=> $stable(bw_q))
		else $error("out of range bandwidth accepted");
	a_rdata_idle: assert property (@(posedge core_clk) disable iff (rst)
		!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data not zero outside a read");

	a_auto_pi: assert property (@(posedge core_clk) disable iff (rst)
		(!proportional_force_input && !auto_cond) |=> !p_only)
		else $error("P-only without a switching condition");
	a_reserved_off: assert property (@(posedge core_clk) disable iff (rst)
		(mode_q == SWITCH_MODE_MAX && !proportional_force_input) |=> !p_only)
		else $error("reserved mode switched to P-only");
	a_torque_below: assert property (@(posedge core_clk) disable iff (rst)
		(mode_q == 8'h01 && !proportional_force_input &&
		torque_percent >= 0 && torque_percent <= thr_signed) |=> !p_only)
		else $error("torque mode switched at or below threshold");
	a_velocity_below: assert property (@(posedge core_clk) disable iff (rst)
		(mode_q == 8'h02 && !proportional_force_input &&
		velocity_rpm >= 0 && velocity_rpm <= thr_signed) |=> !p_only)
		else $error("velocity mode switched at or below threshold");
	a_poserr_below: assert property (@(posedge core_clk) disable iff (rst)
		(mode_q == 8'h03 && !proportional_force_input &&
		position_error >= 0 && position_error <= thr_signed) |=> !p_only)
		else $error("position error mode switched at or below threshold");
	a_neg_torque: assert property (@(posedge core_clk) disable iff (rst)
		(mode_q == 8'h01 && torque_percent < -thr_signed) |=> p_only)
		else $error("negative torque magnitude did not switch");

	a_ff_bypass: assert property (@(posedge core_clk) disable iff (rst)
		(bw_q == 16'h0000 && gain_q != 8'h00 && tick_q) |=>
		ff_filt == $past(ff_raw))
		else $error("zero bandwidth did not bypass the filter");
	a_ff_sum: assert property (@(posedge core_clk) disable iff (rst)
		gain_q != 8'h00 |=>
		velocity_command_out == $past(velocity_command_in + ff_filt))
		else $error("feedforward not added to velocity command");
	a_filter_hold: assert property (@(posedge core_clk) disable iff (rst)
		!tick_q |=> $stable(ff_filt))
		else $error("filter moved outside a control cycle");
	a_tick_pulse: assert property (@(posedge core_clk) disable iff (rst)
		tick_q |=> !tick_q)
		else $error("control cycle enable longer than one clock");
endmodule

// ==== sim/host_model.sv ====
// Host controller model: position ramp and proportional force input.
module host_model (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic cycle_tick,
	input wire logic ramp_en,
	input wire logic force_req,
	output logic signed [31:0] position_command,
	output logic proportional_force_input
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			position_command <= 32'sh0;
			proportional_force_input <= 1'b0;
		end else begin
			if (ramp_en && cycle_tick)
				position_command <= position_command + 32'shA;
			proportional_force_input <= force_req;
		end
	end
endmodule

// ==== sim/servo_ff_and_pi_switch_tb.sv ====
// Self-checking bench for the feedforward and P/PI switching block.
module servo_ff_and_pi_switch_tb;
	import servo_ff_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic servo_on = 1'b0, ramp_en = 1'b0, force_req = 1'b0;
	logic p_only, cycle_tick, pfi;
	logic [15:0] reg_addr = 16'h0, reg_wdata = 16'h0, reg_rdata, igain, d;
	logic signed [31:0] vin = 32'sh0, tq = 32'sh0, vr = 32'sh0, pe = 32'sh0;
	logic signed [31:0] pos, vout, v;
	int bad_count = 0, n_tests = 0, cyc = 0;
	always #25 core_clk = ~core_clk;
	servo_ff_and_pi_switch #(.CMD_WIDTH(32), .CYCLE_DIV(4))
		servo_ff_and_pi_switch_inst (.core_clk(core_clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .servo_on(servo_on),
		.proportional_force_input(pfi), .position_command(pos),
		.velocity_command_in(vin), .torque_percent(tq), .velocity_rpm(vr),
		.position_error(pe), .velocity_integral_gain_param(16'h0123),
		.velocity_command_out(vout), .integral_gain_out(igain),
		.p_only(p_only), .cycle_tick(cycle_tick));
	host_model host_model_inst (.core_clk(core_clk), .rst(rst),
		.cycle_tick(cycle_tick), .ramp_en(ramp_en), .force_req(force_req),
		.position_command(pos), .proportional_force_input(pfi));
	task automatic wr(input logic [15:0] a, input logic [15:0] x);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= x;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic chk_out(input string n, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_reg(input string n, input logic [15:0] a,
		input logic [15:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		chk_out(n, {16'h0, e}, {16'h0, d});
	endtask
	task automatic settle(input int c);
		repeat (c) @(posedge core_clk);
		#1;
	endtask
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 6000) begin
			bad_count++;
			end_sim();
		end
	end
	initial begin
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		chk_reg("mode", ADDR_SWITCH_MODE, 16'h0000);
		chk_reg("thr", ADDR_SWITCH_THRESHOLD, 16'h0064);
		chk_reg("gain", ADDR_FF_GAIN, 16'h0000);
		chk_reg("bw", ADDR_FF_FILTER_BW, 16'h00C8);
		chk_reg("unmapped", 16'h2000, 16'h0000);
		wr(ADDR_SWITCH_THRESHOLD, 16'h0BB9);
		chk_reg("thr over", ADDR_SWITCH_THRESHOLD, 16'h0064);
		wr(ADDR_SWITCH_THRESHOLD, 16'h0BB8);
		chk_reg("thr max", ADDR_SWITCH_THRESHOLD, 16'h0BB8);
		wr(ADDR_SWITCH_THRESHOLD, 16'h0064);
		servo_on <= 1'b1;
		wr(ADDR_SWITCH_MODE, 16'h0001);
		chk_reg("mode on", ADDR_SWITCH_MODE, 16'h0000);
		servo_on <= 1'b0;
		$display("Register test done");
		for (int m = 1; m <= 3; m++) begin
			wr(ADDR_SWITCH_MODE, 16'(m));
			for (int k = 0; k < 2; k++) begin
				v = k ? 32'sh64 : 32'sh65;
				tq <= (m == 1) ? v : 32'sh0;
				vr <= (m == 2) ? v : 32'sh0;
				pe <= (m == 3) ? v : 32'sh0;
				settle(3);
				chk_out("p_only", 32'(k == 0), 32'(p_only));
				chk_out("igain", k ? 32'h123 : 32'h0, 32'(igain));
			end
		end
		tq <= 32'sh1F4;
		vr <= 32'sh1F4;
		pe <= 32'sh1F4;
		for (int m = 0; m <= 4; m += 4) begin
			wr(ADDR_SWITCH_MODE, 16'(m));
			settle(3);
			chk_out("auto off", 32'h0, 32'(p_only));
		end
		force_req <= 1'b1;
		settle(4);
		chk_out("forced", 32'h1, 32'(p_only));
		chk_out("forced igain", 32'h0, 32'(igain));
		chk_reg("status", ADDR_STATUS, 16'h0001);
		force_req <= 1'b0;
		$display("Switching test done");
		vin <= 32'sh3E8;
		wr(ADDR_FF_FILTER_BW, 16'h0000);
		wr(ADDR_FF_GAIN, 16'h0064);
		ramp_en <= 1'b1;
		settle(16);
		chk_out("ff 100", 32'h3F2, vout);
		wr(ADDR_FF_GAIN, 16'h0032);
		settle(16);
		chk_out("ff 50", 32'h3ED, vout);
		wr(ADDR_FF_GAIN, 16'h0065);
		chk_reg("gain over", ADDR_FF_GAIN, 16'h0032);
		wr(ADDR_FF_FILTER_BW, 16'h00C8);
		wr(ADDR_FF_GAIN, 16'h0000);
		settle(16);
		chk_out("ff off", 32'h3E8, vout);
		wr(ADDR_FF_FILTER_BW, 16'h09C5);
		chk_reg("bw over", ADDR_FF_FILTER_BW, 16'h00C8);
		wr(ADDR_FF_FILTER_BW, 16'h0001);
		wr(ADDR_FF_GAIN, 16'h0064);
		settle(16);
		chk_out("ff slow", 32'h3E8, vout);
		wr(ADDR_FF_FILTER_BW, 16'h09C4);
		settle(16);
		chk_out("ff fast", 32'h3F2, vout);
		d = 16'h0;
		repeat (8) begin
			@(posedge core_clk);
			#1 d += 16'(cycle_tick);
		end
		chk_out("ticks", 32'h2, {16'h0, d});
		$display("Feedforward test done");
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		chk_reg("mode rst", ADDR_SWITCH_MODE, 16'h0000);
		chk_reg("gain rst", ADDR_FF_GAIN, 16'h0000);
		$display("Reset test done");
		end_sim();
	end
endmodule
